// file: logic/utfc_pkg.sv
// package with register map, field positions and types for the uart block
package utfc_pkg;
  // register byte addresses (word aligned)
  localparam logic [3:0] utfc_addr_data = 4'h0;   // tx holding write / rx holding read
  localparam logic [3:0] utfc_addr_stat = 4'h4;   // receive and transmit status
  localparam logic [3:0] utfc_addr_ctl0 = 4'h8;   // enables, parity, flow control
  localparam logic [3:0] utfc_addr_ctl1 = 4'hc;   // nine bit mode, match scheme, baud
  localparam logic [3:0] utfc_addr_adr = 4'h0;    // address compare (index 4, see below)
  localparam logic [4:0] utfc_addr_cmp = 5'h10;   // address compare register
  // control 0 fields
  localparam int utfc_c0_ten = 0;     // transmit enable
  localparam int utfc_c0_ren = 1;     // receive enable
  localparam int utfc_c0_pen = 2;     // parity enable
  localparam int utfc_c0_psel = 3;    // odd parity when set
  localparam int utfc_c0_flow_ctrl_enable = 4;    // flow control enable
  localparam int utfc_c0_stop2 = 5;   // two stop bits
  localparam int utfc_c0_erronly = 6; // interrupt on errors only
  // control 1 fields
  localparam int utfc_c1_nine_bit_mode_select = 0;    // nine bit mode select
  localparam int utfc_c1_outgoing_addr_flag = 1;    // outgoing address flag
  localparam int utfc_c1_addr_match_scheme = 2;    // match scheme, two bits
  localparam int utfc_c1_baud = 16;   // baud divisor, sixteen bits
  // status fields
  localparam int utfc_s_rda = 0;      // receive data available
  localparam int utfc_s_pe = 1;       // parity error
  localparam int utfc_s_oe = 2;       // overrun
  localparam int utfc_s_fe = 3;       // framing error
  localparam int utfc_s_brk = 4;      // break detected
  localparam int utfc_s_tx_holding_empty = 5;     // tx holding empty
  localparam int utfc_s_txe = 6;      // transmitter idle
  localparam int utfc_s_mprx = 7;     // last received ninth bit
  localparam int utfc_s_newfrm = 8;   // first data byte of a matched frame, scheme 2 (scheme 3 drops address bytes, so mprx stays low)
  // reset values
  localparam logic [31:0] utfc_ctl0_rst = 32'h0000_0000;
  localparam logic [15:0] utfc_baud_rst = 16'h0010;
  // oversampling ratio of the receiver
  localparam logic [3:0] utfc_os_last = 4'hf;
  localparam logic [3:0] utfc_os_mid = 4'h7;
  // character bit count
  localparam logic [3:0] utfc_nbits = 4'h8;
  // match schemes
  localparam logic [1:0] utfc_mp_all = 2'h0;
  localparam logic [1:0] utfc_mp_addr = 2'h1;
  localparam logic [1:0] utfc_mp_match = 2'h2;
  localparam logic [1:0] utfc_mp_data = 2'h3;
  // shared character format
  typedef struct packed {
    logic par_en;
    logic par_odd;
    logic nine;
    logic stop2;
  } utfc_fmt_s;
  // transmitter states
  typedef enum logic [5:0] {
    utfc_tx_idle = 6'h01,
    utfc_tx_start = 6'h02,
    utfc_tx_data = 6'h04,
    utfc_tx_par = 6'h08,
    utfc_tx_stop = 6'h10,
    utfc_tx_stop2 = 6'h20
  } utfc_tx_e;
endpackage

// file: logic/utfc_rx.sv
// receiver: oversampled start detect, data, ninth bit, stop check
`timescale 1ns/1ps
module utfc_rx (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // timing and format
  input wire logic os_tick,
  input wire logic rx_en,
  input wire utfc_pkg::utfc_fmt_s fmt,
  // line
  input wire logic rxd,
  // received character
  output logic done,
  output logic [7:0] data,
  output logic ninth,
  output logic par_err,
  output logic frm_err,
  output logic brk
);
  import utfc_pkg::*;
  logic busy, next_busy; // inside a character
  logic [3:0] os, next_os; // oversample phase
  logic [3:0] idx, next_idx; // bit index, 0 is start
  logic [9:0] sh, next_sh; // collected bits
  logic next_done, next_ninth, next_par_err, next_frm_err, next_brk;
  logic [7:0] next_data;
  logic armed, next_armed; // line seen high while idle since the last start
  logic extra; // parity or ninth bit present
  logic [3:0] last_idx; // index of stop bit
  assign extra = fmt.nine | fmt.par_en;
  assign last_idx = extra ? 4'ha : 4'h9;
  // next state of the sampler
  always_comb begin
    next_busy = busy;
    next_os = os;
    next_idx = idx;
    next_sh = sh;
    next_done = 1'b0;
    next_data = data;
    next_ninth = ninth;
    next_par_err = par_err;
    next_frm_err = frm_err;
    next_brk = brk;
    next_armed = armed;
    if (!busy) begin
      // a low stop bit or a held break must not restart the sampler at once
      if (rxd) begin
        next_armed = 1'b1;
      end
      // start edge only while enabled
      if (rx_en && armed && !rxd && os_tick) begin
        next_busy = 1'b1;
        next_armed = 1'b0;
        next_os = 4'h0;
        next_idx = 4'h0;
      end
    end else if (os_tick) begin
      next_os = os + 4'h1;
      if (os == utfc_os_mid) begin
        if (idx == 4'h0 && rxd) begin
          next_busy = 1'b0; // false start
        end else if (idx == last_idx) begin
          // lsb first, stop at end
          next_busy = 1'b0;
          next_done = 1'b1;
          next_data = sh[8:1];
          next_ninth = extra ? sh[9] : 1'b0; // ninth in parity slot
          next_par_err = fmt.par_en && !fmt.nine &&
                         ((^sh[9:1]) != fmt.par_odd);
          next_frm_err = !rxd;
          next_brk = !rxd && (sh[9:1] == 9'h000);
        end else begin
          next_sh = {rxd, sh[9:1]};
          next_idx = idx + 4'h1;
          if (!extra && idx == 4'h8) begin
            next_sh = {1'b0, rxd, sh[9:2]};
          end
        end
      end
    end
  end
  // registers of the sampler
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      os <= 4'h0;
      idx <= 4'h0;
      sh <= 10'h000;
      done <= 1'b0;
      data <= 8'h00;
      ninth <= 1'b0;
      par_err <= 1'b0;
      frm_err <= 1'b0;
      brk <= 1'b0;
      armed <= 1'b0;
    end else begin
      busy <= next_busy;
      os <= next_os;
      idx <= next_idx;
      sh <= next_sh;
      done <= next_done;
      data <= next_data;
      ninth <= next_ninth;
      par_err <= next_par_err;
      frm_err <= next_frm_err;
      brk <= next_brk;
      armed <= next_armed;
    end
  end
endmodule

// file: logic/utfc_top.sv
// uart with flow control: register slave, transmitter, receive status
//
// Notes on behaviour
// - tx interrupt means holding register free
// - enabled empty holding register interrupts at once
// - written byte moves to shifter, then sent
// - transmit only while tx enable set
// - receive only while rx enable set
// - even/odd parity, none in nine bit mode
// - mode select bit gives nine bit operation
// - ninth bit set marks address byte
// - two bit field picks match scheme
// - own address held in compare register
// - data available flag tracks holding register
// - rx interrupt on data and on errors
// - status tells error, break, data apart
// - option: interrupt on errors only
// - flow control only when enabled
// - sample clear to send before each start
// - character in flight always finishes
// - start, 8 bits lsb first, parity, stops
// - empty flag sets after first bit
// - ninth bit sits in parity slot
`timescale 1ns/1ps
module utfc_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial pins
  output logic txd,
  input wire logic rxd,
  input wire logic cts_n,
  // interrupt requests
  output logic tx_irq,
  output logic rx_irq
);
  import utfc_pkg::*;
  // control registers
  logic [6:0] ctl0, next_ctl0;
  logic [3:0] ctl1, next_ctl1; // nine_bit_mode_select, outgoing_addr_flag, addr_match_scheme
  logic [15:0] baud, next_baud;
  logic [7:0] cmp_addr, next_cmp_addr; // own node address
  // bus answer
  logic next_waitrequest;
  logic [31:0] next_readdata;
  // transmit side
  utfc_tx_e tx_st, next_tx_st;
  logic [7:0] thr, next_thr; // holding register
  logic thr_bit9, next_thr_bit9; // ninth bit latched with the byte
  logic tx_holding_empty, next_tx_holding_empty;
  logic [8:0] tsr, next_tsr; // shift register incl. extra bit
  logic [3:0] tbit, next_tbit;
  logic [3:0] tos, next_tos; // bit length in oversample ticks
  logic next_txd;
  logic cts_ok; // sampled a cycle before start
  // receive holding and status
  logic [7:0] rhr, next_rhr;
  logic rx_data_available, next_rx_data_available;
  logic pe, fe, oe, bk, mprx, newfrm;
  logic next_pe, next_fe, next_oe, next_bk, next_mprx, next_newfrm;
  logic in_frame, next_in_frame; // matched frame for schemes 2 and 3
  logic next_tx_irq, next_rx_irq;
  // baud divider
  logic [15:0] bcnt, next_bcnt;
  logic os_tick;
  // receiver outputs
  logic rx_done, rx_ninth, rx_pe, rx_fe, rx_brk;
  logic [7:0] rx_byte;
  utfc_fmt_s fmt;
  logic wr, rd, acc_ok;
  logic wr_data, rd_data;
  logic tx_en, flow_ctrl_enable, nine_bit_mode_select, outgoing_addr_flag;
  logic [1:0] addr_match_scheme;

  // field decode of control
  assign tx_en = ctl0[utfc_c0_ten];
  assign flow_ctrl_enable = ctl0[utfc_c0_flow_ctrl_enable];
  assign nine_bit_mode_select = ctl1[utfc_c1_nine_bit_mode_select];
  assign outgoing_addr_flag = ctl1[utfc_c1_outgoing_addr_flag];
  assign addr_match_scheme = ctl1[utfc_c1_addr_match_scheme +: 2];
  // one format for both directions
  assign fmt = '{par_en: ctl0[utfc_c0_pen] & ~nine_bit_mode_select,
                 par_odd: ctl0[utfc_c0_psel],
                 nine: nine_bit_mode_select,
                 stop2: ctl0[utfc_c0_stop2]};
  // bus strobes; one wait cycle then answer
  assign acc_ok = avs_waitrequest == 1'b0;
  assign wr = avs_write & acc_ok;
  assign rd = avs_read & acc_ok;
  assign wr_data = wr && avs_address == {1'b0, utfc_addr_data};
  assign rd_data = rd && avs_address == {1'b0, utfc_addr_data};
  // low level permits transmission gated by enable
  assign cts_ok = !flow_ctrl_enable || !cts_n;

  // baud divider giving oversample ticks
  always_comb begin
    next_bcnt = bcnt + 16'h0001;
    os_tick = 1'b0;
    if (bcnt >= baud) begin
      next_bcnt = 16'h0000;
      os_tick = 1'b1;
    end
  end

  // bus slave and registers
  always_comb begin
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    next_ctl0 = ctl0;
    next_ctl1 = ctl1;
    next_baud = baud;
    next_cmp_addr = cmp_addr;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
    end
    if (avs_read && avs_waitrequest) begin
      case (avs_address)
        {1'b0, utfc_addr_data}: next_readdata = {24'h0, rhr};
        {1'b0, utfc_addr_stat}: begin
          // cause of receive interrupt visible
          next_readdata = 32'h0;
          next_readdata[utfc_s_rda] = rx_data_available;
          next_readdata[utfc_s_pe] = pe;
          next_readdata[utfc_s_oe] = oe;
          next_readdata[utfc_s_fe] = fe;
          next_readdata[utfc_s_brk] = bk;
          next_readdata[utfc_s_tx_holding_empty] = tx_holding_empty;
          next_readdata[utfc_s_txe] = tx_st == utfc_tx_idle;
          next_readdata[utfc_s_mprx] = mprx;
          next_readdata[utfc_s_newfrm] = newfrm;
        end
        {1'b0, utfc_addr_ctl0}: next_readdata = {25'h0, ctl0};
        {1'b0, utfc_addr_ctl1}: next_readdata = {baud, 12'h0, ctl1};
        utfc_addr_cmp: next_readdata = {24'h0, cmp_addr};
        default: next_readdata = 32'h0; // unmapped reads zero
      endcase
    end
    if (wr) begin
      case (avs_address)
        {1'b0, utfc_addr_ctl0}: next_ctl0 = avs_writedata[6:0];
        {1'b0, utfc_addr_ctl1}: begin
          next_ctl1 = avs_writedata[3:0];
          next_baud = avs_writedata[utfc_c1_baud +: 16];
        end
        utfc_addr_cmp: next_cmp_addr = avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // transmitter
  always_comb begin
    next_tx_st = tx_st;
    next_thr = thr;
    next_thr_bit9 = thr_bit9;
    next_tx_holding_empty = tx_holding_empty;
    next_tsr = tsr;
    next_tbit = tbit;
    next_tos = tos;
    next_txd = txd;
    if (os_tick && tx_st != utfc_tx_idle) begin
      next_tos = tos + 4'h1;
    end
    case (tx_st)
      utfc_tx_idle: begin
        next_txd = 1'b1;
        // load only with enable, free line and cts seen now
        if (!tx_holding_empty && tx_en && cts_ok) begin
          next_tx_st = utfc_tx_start; // hardware moves byte on
          next_tsr = {fmt.nine ? thr_bit9 : ((^thr) ^ fmt.par_odd), thr};
          next_tos = 4'h0;
          next_txd = 1'b0;
        end
      end
      utfc_tx_start: begin
        if (os_tick && tos == utfc_os_last) begin
          next_tx_st = utfc_tx_data;
          next_tbit = 4'h0;
          next_txd = tsr[0]; // lsb first
          // first bit gone, holding register free again
          next_tx_holding_empty = 1'b1;
        end
      end
      utfc_tx_data: begin
        if (os_tick && tos == utfc_os_last) begin
          if (tbit == utfc_nbits - 4'h1) begin
            if (fmt.par_en || fmt.nine) begin
              next_tx_st = utfc_tx_par; // extra bit before stop
              next_txd = tsr[8]; // ninth bit or parity
            end else begin
              next_tx_st = utfc_tx_stop;
              next_txd = 1'b1;
            end
          end else begin
            next_tbit = tbit + 4'h1;
            next_txd = tsr[next_tbit[2:0]];
          end
        end
      end
      utfc_tx_par: begin
        if (os_tick && tos == utfc_os_last) begin
          next_tx_st = utfc_tx_stop;
          next_txd = 1'b1;
        end
      end
      utfc_tx_stop: begin
        // cts ignored until character ends
        if (os_tick && tos == utfc_os_last) begin
          next_tx_st = fmt.stop2 ? utfc_tx_stop2 : utfc_tx_idle;
        end
      end
      utfc_tx_stop2: begin
        if (os_tick && tos == utfc_os_last) begin
          next_tx_st = utfc_tx_idle;
        end
      end
      default: next_tx_st = utfc_tx_idle;
    endcase
    // software write fills holding register, empty clears
    if (wr_data) begin
      next_thr = avs_writedata[7:0];
      next_thr_bit9 = outgoing_addr_flag;
      next_tx_holding_empty = 1'b0;
    end
    // empty and enabled raises at once
    next_tx_irq = next_tx_holding_empty & tx_en;
  end

  // receive holding register, status and match schemes
  always_comb begin
    logic accept;
    logic is_addr;
    accept = 1'b0;
    is_addr = rx_ninth & nine_bit_mode_select;
    next_rhr = rhr;
    next_rx_data_available = rx_data_available;
    next_pe = pe;
    next_fe = fe;
    next_oe = oe;
    next_bk = bk;
    next_mprx = mprx;
    next_newfrm = newfrm;
    next_in_frame = in_frame;
    // reading data clears rda and error flags, not mprx or newfrm; an arrival below still wins
    if (rd_data) begin
      next_rx_data_available = 1'b0;
      next_pe = 1'b0;
      next_fe = 1'b0;
      next_oe = 1'b0;
      next_bk = 1'b0;
    end
    if (rx_done) begin
      accept = 1'b1;
      if (nine_bit_mode_select) begin
        case (addr_match_scheme)
          utfc_mp_all: accept = 1'b1;
          utfc_mp_addr: accept = is_addr;
          utfc_mp_match: begin
            if (is_addr) begin
              next_in_frame = rx_byte == cmp_addr;
            end
            accept = is_addr ? (rx_byte == cmp_addr) : in_frame;
          end
          utfc_mp_data: begin
            if (is_addr) begin
              next_in_frame = rx_byte == cmp_addr;
            end
            accept = !is_addr && in_frame;
          end
          default: accept = 1'b1;
        endcase
      end
      accept = accept | rx_fe | rx_brk;
      if (accept) begin
        if (rx_data_available && !rd_data) begin
          next_oe = 1'b1; // keep valid byte
        end else begin
          next_rhr = rx_byte;
          next_rx_data_available = 1'b1;
          next_pe = rx_pe;
          next_fe = rx_fe;
          next_bk = rx_brk;
          next_mprx = is_addr;
          next_newfrm = !is_addr && addr_match_scheme[1] && (is_addr != mprx) && mprx;
        end
      end
    end
    // data and errors, or errors only
    next_rx_irq = (next_pe | next_fe | next_oe | next_bk) |
                  (next_rx_data_available & ~ctl0[utfc_c0_erronly]);
  end

  // receiver instance, enable gates start detect
  utfc_rx u_rx (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .os_tick(os_tick),
    .rx_en(ctl0[utfc_c0_ren]),
    .fmt(fmt),
    .rxd(rxd),
    .done(rx_done),
    .data(rx_byte),
    .ninth(rx_ninth),
    .par_err(rx_pe),
    .frm_err(rx_fe),
    .brk(rx_brk)
  );

  // all state registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctl0 <= utfc_ctl0_rst[6:0];
      ctl1 <= 4'h0;
      baud <= utfc_baud_rst;
      cmp_addr <= 8'h00;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      tx_st <= utfc_tx_idle;
      thr <= 8'h00;
      thr_bit9 <= 1'b0;
      tx_holding_empty <= 1'b1;
      tsr <= 9'h000;
      tbit <= 4'h0;
      tos <= 4'h0;
      txd <= 1'b1;
      rhr <= 8'h00;
      rx_data_available <= 1'b0;
      {pe, fe, oe, bk, mprx, newfrm, in_frame} <= 7'h00;
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
      bcnt <= 16'h0000;
    end else begin
      ctl0 <= next_ctl0;
      ctl1 <= next_ctl1;
      baud <= next_baud;
      cmp_addr <= next_cmp_addr;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
      tx_st <= next_tx_st;
      thr <= next_thr;
      thr_bit9 <= next_thr_bit9;
      tx_holding_empty <= next_tx_holding_empty;
      tsr <= next_tsr;
      tbit <= next_tbit;
      tos <= next_tos;
      txd <= next_txd;
      rhr <= next_rhr;
      rx_data_available <= next_rx_data_available;
      {pe, fe, oe, bk, mprx, newfrm, in_frame} <=
        {next_pe, next_fe, next_oe, next_bk, next_mprx, next_newfrm, next_in_frame};
      tx_irq <= next_tx_irq;
      rx_irq <= next_rx_irq;
      bcnt <= next_bcnt;
    end
  end

  // assertions
  property p_tx_irq;
    @(posedge ref_clk) disable iff (!nrst)
      (tx_holding_empty && tx_en && !wr_data) |=> tx_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("tx irq missing");
  property p_no_start_disabled;
    @(posedge ref_clk) disable iff (!nrst)
      (tx_st == utfc_tx_idle && !tx_en) |=> tx_st == utfc_tx_idle;
  endproperty
  a_no_start_disabled: assert property (p_no_start_disabled)
    else $error("start without enable");
  property p_cts_block;
    @(posedge ref_clk) disable iff (!nrst)
      (tx_st == utfc_tx_idle && flow_ctrl_enable && cts_n) |=> tx_st == utfc_tx_idle;
  endproperty
  a_cts_block: assert property (p_cts_block) else $error("start against cts");
  property p_finish;
    @(posedge ref_clk) disable iff (!nrst)
      (tx_st == utfc_tx_data && cts_n) |=> tx_st != utfc_tx_idle;
  endproperty
  a_finish: assert property (p_finish) else $error("character cut short");
  property p_start_low;
    @(posedge ref_clk) disable iff (!nrst)
      tx_st == utfc_tx_start |-> txd == 1'b0;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
  property p_tx_holding_empty_write;
    @(posedge ref_clk) disable iff (!nrst)
      wr_data |=> !tx_holding_empty;
  endproperty
  a_tx_holding_empty_write: assert property (p_tx_holding_empty_write) else $error("empty not cleared");
  property p_rda;
    @(posedge ref_clk) disable iff (!nrst)
      (rx_done && !nine_bit_mode_select && !rx_data_available) |=> rx_data_available;
  endproperty
  a_rda: assert property (p_rda) else $error("data flag not set");
  property p_rx_irq;
    @(posedge ref_clk) disable iff (!nrst)
      (rx_data_available && !rd_data && !ctl0[utfc_c0_erronly]) |=> rx_irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq missing");
endmodule

// file: test/utfc_remote.sv
// remote serial node model: frames onto rxd, decodes txd, drives clear to send
`timescale 1ns/1ps
module utfc_remote (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // serial pins
  input wire logic txd,
  output logic rxd,
  output logic cts_n,
  // bench control
  input wire logic hold_off
);
  localparam int bit_cyc = 32; // divisor 1: sixteen ticks of two cycles
  initial rxd = 1'b1; // idle at mark level
  // held off long before any start; low lets the device go
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cts_n <= 1'b1;
    else cts_n <= hold_off;
  end
  // start, 8 bits lsb first, optional ninth, then stop level
  task automatic send(input logic [8:0] c, input logic nine, input logic stop);
    int i;
    rxd <= 1'b0;
    repeat (bit_cyc) @(posedge ref_clk);
    for (i = 0; i < 9; i++) begin
      if (i < 8 || nine) begin
        rxd <= c[i];
        repeat (bit_cyc) @(posedge ref_clk);
      end
    end
    rxd <= stop;
    repeat (bit_cyc) @(posedge ref_clk);
    rxd <= 1'b1;
  endtask
  // decode one character: c[7:0] data, c[8] ninth, c[9] stop
  task automatic recv(output logic [9:0] c, input logic nine);
    int i;
    int n;
    n = 0;
    c = '1;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (bit_cyc / 2) @(posedge ref_clk);
    for (i = 0; i < 10; i++) begin
      if (i != 8 || nine) begin
        repeat (bit_cyc) @(posedge ref_clk);
        c[i] = txd;
      end
    end
    repeat (bit_cyc) @(posedge ref_clk);
  endtask
endmodule

// file: test/utfc_top_bench.sv
// self-checking testbench for the uart with flow control
`timescale 1ns/1ps
module utfc_top_bench;
  import utfc_pkg::*;
  // design side
  logic ref_clk, nrst, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic txd, rxd, cts_n, tx_irq, rx_irq, hold_off;
  logic [9:0] ch; // last decoded character
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  localparam int bc = 32; // cycles per serial bit
  localparam logic [31:0] baud1 = 32'h0001_0000;
  utfc_top utfc_top_inst (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .txd(txd),
    .rxd(rxd), .cts_n(cts_n), .tx_irq(tx_irq), .rx_irq(rx_irq));
  utfc_remote utfc_remote_inst (.ref_clk(ref_clk), .nrst(nrst), .txd(txd), .rxd(rxd),
    .cts_n(cts_n), .hold_off(hold_off));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge ref_clk);
    // only the hang guard ends a wait that never sees the answer
    while (avs_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic t_regs();
    chk("txd_idle", 32'(txd), 1);
    chk("tx_irq_rst", 32'(tx_irq), 0);
    bus(0, 5'h0c, 0);
    chk("baud_rst", rdv, {utfc_baud_rst, 16'h0});
    bus(1, 5'h0c, baud1);
    bus(1, utfc_addr_cmp, 32'h42);
    bus(0, utfc_addr_cmp, 0);
    chk("cmp", rdv, 32'h42);
    bus(0, 5'h14, 0);
    chk("unmapped", rdv, 0);
    $display("test regs done");
  endtask
  task automatic t_tx();
    bus(1, 5'h08, 32'h1);
    waitc(2);
    chk("tx_irq_on", 32'(tx_irq), 1);
    bus(1, 5'h00, 32'ha5);
    bus(0, 5'h04, 0);
    chk("tx_holding_empty_clr", 32'(rdv[utfc_s_tx_holding_empty]), 0);
    utfc_remote_inst.recv(ch, 0);
    chk("tx_a5", 32'(ch), 32'h3a5);
    chk("tx_irq_back", 32'(tx_irq), 1);
    bus(1, 5'h08, 32'h0);
    bus(1, 5'h00, 32'h3c);
    waitc(4 * bc);
    chk("tx_gated", 32'(txd), 1);
    bus(1, 5'h08, 32'h1);
    utfc_remote_inst.recv(ch, 0);
    chk("tx_3c", 32'(ch), 32'h33c);
    $display("test tx done");
  endtask
  // even, odd, then nine bit mode with both address flags
  task automatic t_fmt();
    int k;
    for (k = 0; k < 4; k++) begin
      bus(1, 5'h0c, baud1 | (k > 1 ? 32'h1 | 32'(k[0]) << 1 : 32'h0));
      bus(1, 5'h08, 32'h5 | 32'(k[0]) << 3);
      bus(1, 5'h00, 32'h07);
      utfc_remote_inst.recv(ch, 1);
      chk("fmt", 32'(ch), {22'h0, 1'b1, (k > 1 ? k[0] : !k[0]), 8'h07});
    end
    $display("test fmt done");
  endtask
  task automatic t_cts();
    bus(1, 5'h0c, baud1);
    hold_off <= 1'b1;
    bus(1, 5'h08, 32'h1);
    bus(1, 5'h00, 32'h22);
    utfc_remote_inst.recv(ch, 0);
    chk("cts_off", 32'(ch), 32'h322);
    bus(1, 5'h08, 32'h11);
    bus(1, 5'h00, 32'h5a);
    waitc(4 * bc);
    chk("cts_hold", 32'(txd), 1);
    hold_off <= 1'b0;
    fork
      utfc_remote_inst.recv(ch, 0);
      begin
        waitc(3 * bc);
        hold_off <= 1'b1;
      end
    join
    chk("cts_mid", 32'(ch), 32'h35a);
    bus(1, 5'h00, 32'h11);
    waitc(4 * bc);
    chk("cts_hold2", 32'(txd), 1);
    hold_off <= 1'b0;
    utfc_remote_inst.recv(ch, 0);
    chk("cts_go", 32'(ch), 32'h311);
    $display("test cts done");
  endtask
  task automatic t_rx();
    bus(1, 5'h08, 32'h2);
    utfc_remote_inst.send(9'h03c, 0, 1);
    waitc(bc);
    chk("rx_irq", 32'(rx_irq), 1);
    bus(0, 5'h04, 0);
    chk("rda_set", 32'(rdv[utfc_s_rda]), 1);
    bus(0, 5'h00, 0);
    chk("rx_3c", rdv, 32'h3c);
    bus(0, 5'h04, 0);
    chk("rda_clr", 32'(rdv[utfc_s_rda]), 0);
    utfc_remote_inst.send(9'h055, 0, 0);
    waitc(bc);
    bus(0, 5'h04, 0);
    chk("frm_err", 32'(rdv[utfc_s_fe]), 1);
    chk("err_irq", 32'(rx_irq), 1);
    bus(0, 5'h00, 0);
    bus(1, 5'h08, 32'h42);
    utfc_remote_inst.send(9'h066, 0, 1);
    waitc(bc);
    chk("erronly", 32'(rx_irq), 0);
    bus(0, 5'h00, 0);
    bus(1, 5'h08, 32'h0);
    utfc_remote_inst.send(9'h077, 0, 1);
    waitc(bc);
    bus(0, 5'h04, 0);
    chk("ren_off", 32'(rdv[utfc_s_rda]), 0);
    bus(1, 5'h0c, baud1 | 32'h9);
    bus(1, 5'h08, 32'h2);
    utfc_remote_inst.send(9'h141, 1, 1);
    waitc(bc);
    chk("mp_miss", 32'(rx_irq), 0);
    utfc_remote_inst.send(9'h142, 1, 1);
    waitc(bc);
    chk("mp_hit", 32'(rx_irq), 1);
    bus(0, 5'h00, 0);
    bus(1, 5'h0c, baud1 | 32'h5);
    utfc_remote_inst.send(9'h033, 1, 1);
    waitc(bc);
    chk("mp_data_skip", 32'(rx_irq), 0);
    utfc_remote_inst.send(9'h150, 1, 1);
    waitc(bc);
    chk("mp_addr", 32'(rx_irq), 1);
    bus(0, 5'h00, 0);
    bus(1, 5'h0c, baud1);
    bus(1, 5'h08, 32'h6);
    utfc_remote_inst.send(9'h007, 1, 1);
    waitc(bc);
    bus(0, 5'h04, 0);
    chk("par_err", 32'(rdv[utfc_s_pe]), 1);
    $display("test rx done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    nrst = 1'b0;
    avs_address = 5'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    hold_off = 1'b0;
    waitc(6);
    nrst <= 1'b1;
    waitc(1);
    t_regs();
    t_tx();
    t_fmt();
    t_cts();
    t_rx();
    final_report();
  end
endmodule
